// ### logic/can_tx_pkg.sv
package can_tx_pkg;

  localparam int NBOX = 16;
  localparam int ID_W = 11;
  localparam int IDX_W = 14;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] EN_LO_IDX = 14'h2300;
  localparam logic [IDX_W-1:0] EN_HI_IDX = 14'h2301;
  localparam logic [IDX_W-1:0] DIR_LO_IDX = 14'h2302;
  localparam logic [IDX_W-1:0] DIR_HI_IDX = 14'h2303;
  localparam logic [IDX_W-1:0] TRS_LO_IDX = 14'h2304;
  localparam logic [IDX_W-1:0] TRS_HI_IDX = 14'h2305;
  localparam logic [IDX_W-1:0] TA_LO_IDX = 14'h2308;
  localparam logic [IDX_W-1:0] TA_HI_IDX = 14'h2309;
  localparam logic [IDX_W-1:0] MCR_IDX = 14'h2310;

  // Field positions and reset values
  localparam int ORDER_BIT = 3;
  localparam logic [15:0] EN_RST = 16'h0000;
  localparam logic [14:0] DIR_RST = 15'h0000;
  localparam logic [14:0] TRS_RST = 15'h0000;
  localparam logic [14:0] TA_RST = 15'h0000;
  localparam logic [3:0] PTR_RST = 4'h0;

  // Longest frame in bit times, stuff bits included
  localparam int FRAME_MAX_BITS = 152;

endpackage

// ### logic/tx_sched_if.sv
`timescale 1ns/10ps
interface tx_sched_if;
  import can_tx_pkg::*;
  logic [NBOX-1:0] req;
  logic [3:0] start;
  logic mode;
  logic [NBOX*ID_W-1:0] ids;
  logic found;
  logic [3:0] pick;
  modport ctl (output req, output start, output mode, output ids, input found, input pick);
  modport sel (input req, input start, input mode, input ids, output found, output pick);
endinterface

// ### logic/tx_pick.sv
`timescale 1ns/10ps
module tx_pick
  import can_tx_pkg::*;
(
  tx_sched_if.sel s
);

  // Mode 0: first request from the start box upward, wrapping.
  // Mode 1: lowest identifier wins; ties go to the lower box.
  always_comb begin
    logic [3:0] idx;
    logic [ID_W-1:0] best;
    logic [ID_W-1:0] cur;
    idx = 4'h0;
    best = '1;
    cur = '0;
    s.found = 1'b0;
    s.pick = 4'h0;
    for (int i = 0; i < NBOX; i++) begin
      if (!s.mode) begin
        idx = 4'(s.start + 4'(i));
        if (!s.found && s.req[idx]) begin
          s.found = 1'b1;
          s.pick = idx;
        end
      end else begin
        cur = s.ids[i*ID_W +: ID_W];
        if (s.req[i] && (!s.found || cur < best)) begin
          s.found = 1'b1;
          s.pick = 4'(i);
          best = cur;
        end
      end
    end
  end

endmodule

// ### logic/can_mailbox_tx_control.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
// Function
// - Mailbox enable bit gates mailbox access
// - Direction 0 transmits, 1 receives
// - Last box direction reads 1, writes ignored
// - Rx finishes after switch to transmit; pending set, no irq
// - Tx finishes after switch to receive; ack set, no irq
// - Send enabled transmit boxes with request, sequentially
// - Request not settable on receive boxes
// - Pending request blocks mailbox writes
// - Request cleared only on success; retry
// - Control bit 3 selects transmit order
// - Order 0: rotate from box after last
// - Order 0: failure restarts scan at box
// - Order 1: highest priority identifier, repick
// - Order 1: error resends same box
// - No request bit for last box
// - Mailbox writable when enabled and no request pending
// - Disabling mid-transmission does not abort it
// - Request set by writing 1, 0 ignored
// - Success sets ack; 1 to ack/request clears
module can_mailbox_tx_control
  import can_tx_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Mailbox store
  input wire logic [NBOX*ID_W-1:0] box_id,
  output logic [NBOX-1:0] box_wr_ok,
  // Protocol engine, transmit
  output logic tx_go,
  output logic [3:0] tx_box,
  output logic tx_busy,
  input wire logic tx_ok,
  input wire logic tx_lost,
  input wire logic tx_err,
  output logic tx_irq_set,
  // Protocol engine, receive
  input wire logic rx_start,
  input wire logic [3:0] rx_box_in,
  input wire logic rx_end,
  output logic rx_pend_set,
  output logic rx_irq_set,
  output logic [3:0] rx_pend_box
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t st;
    logic [3:0] box;
    logic [3:0] ptr;
    logic [15:0] en;
    logic [14:0] dir;
    logic [14:0] transmit_request_bits;
    logic [14:0] ta;
    logic order;
    logic ap_wr;
    logic ap_rd;
    logic [IDX_W-1:0] ap_idx;
    logic rd_wait;
    logic [7:0] rdata;
    logic go;
    logic tx_chg;
    logic tx_irq;
    logic rx_busy;
    logic [3:0] rx_box;
    logic rx_chg;
    logic rx_pend;
    logic rx_irq;
  } ctl_t;

  ctl_t q;
  ctl_t d;
  logic [15:0] dir16;
  logic [15:0] trs16;
  logic [15:0] ta16;
  logic [15:0] wv;
  logic [7:0] w;

  tx_sched_if s ();

  tx_pick u_pick (
    .s (s)
  );

  assign dir16 = {1'b1, q.dir};
  assign trs16 = {1'b0, q.transmit_request_bits};
  assign ta16 = {1'b0, q.ta};
  assign w = hwdata[7:0];
  assign wv = (q.ap_idx[0] == 1'b0) ? {8'h00, w} : {w, 8'h00};

  assign s.req = {1'b0, q.transmit_request_bits & ~q.dir & q.en[14:0]};
  assign s.start = q.ptr;
  assign s.mode = q.order;
  assign s.ids = box_id;

  assign box_wr_ok = q.en & ~trs16;

  assign hreadyout = !(q.ap_rd && !q.rd_wait);
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, q.rdata};
  assign tx_go = q.go;
  assign tx_box = q.box;
  assign tx_busy = (q.st == ST_SEND);
  assign tx_irq_set = q.tx_irq;
  assign rx_pend_set = q.rx_pend;
  assign rx_irq_set = q.rx_irq;
  assign rx_pend_box = q.rx_box;

  always_comb begin
    d = q;
    d.go = 1'b0;
    d.tx_irq = 1'b0;
    d.rx_pend = 1'b0;
    d.rx_irq = 1'b0;

    // Address phase capture; reads get one wait state
    d.rd_wait = q.ap_rd && !q.rd_wait;
    if (hready) begin
      d.ap_wr = hsel && htrans[1] && hwrite;
      d.ap_rd = hsel && htrans[1] && !hwrite;
      if (hsel && htrans[1]) begin
        d.ap_idx = haddr[15:2];
      end
    end

    // Write data phase
    if (q.ap_wr) begin
      unique case (q.ap_idx)
        EN_LO_IDX: d.en[7:0] = w;
        EN_HI_IDX: d.en[15:8] = w;
        DIR_LO_IDX: d.dir[7:0] = w;
        DIR_HI_IDX: d.dir[14:8] = w[6:0];
        TRS_LO_IDX, TRS_HI_IDX: begin
          d.transmit_request_bits = q.transmit_request_bits | (wv[14:0] & ~q.dir);
          d.ta = q.ta & ~wv[14:0];
        end
        TA_LO_IDX, TA_HI_IDX: d.ta = q.ta & ~wv[14:0];
        MCR_IDX: d.order = w[ORDER_BIT];
        default: d.order = q.order;
      endcase
    end

    // Read data, sampled after any write of the previous transfer
    if (q.ap_rd && !q.rd_wait) begin
      unique case (q.ap_idx)
        EN_LO_IDX: d.rdata = q.en[7:0];
        EN_HI_IDX: d.rdata = q.en[15:8];
        DIR_LO_IDX: d.rdata = dir16[7:0];
        DIR_HI_IDX: d.rdata = dir16[15:8];
        TRS_LO_IDX: d.rdata = trs16[7:0];
        TRS_HI_IDX: d.rdata = trs16[15:8];
        TA_LO_IDX: d.rdata = ta16[7:0];
        TA_HI_IDX: d.rdata = ta16[15:8];
        MCR_IDX: d.rdata = 8'(q.order) << ORDER_BIT;
        default: d.rdata = 8'h00;
      endcase
    end

    // Transmit scheduling
    unique case (q.st)
      ST_IDLE: begin
        if (s.found) begin
          d.box = s.pick;
          d.go = 1'b1;
          d.tx_chg = 1'b0;
          d.st = ST_SEND;
        end
      end
      ST_SEND: begin
        // Direction or enable changes do not abort the frame
        if (dir16[q.box]) begin
          d.tx_chg = 1'b1;
        end
        if (tx_ok) begin
          d.transmit_request_bits[q.box[3:0]] = 1'b0;
          d.ta[q.box[3:0]] = 1'b1;
          d.tx_irq = !(q.tx_chg || dir16[q.box]);
          d.ptr = 4'(q.box + 4'h1);
          d.st = ST_IDLE;
        end else if (tx_lost) begin
          d.ptr = q.box;
          d.st = ST_IDLE;
        end else if (tx_err) begin
          if (q.order) begin
            d.go = 1'b1;
          end else begin
            d.ptr = q.box;
            d.st = ST_IDLE;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // Receive completion bookkeeping
    if (q.rx_busy && !dir16[q.rx_box]) begin
      d.rx_chg = 1'b1;
    end
    if (rx_start) begin
      d.rx_busy = 1'b1;
      d.rx_box = rx_box_in;
      d.rx_chg = 1'b0;
    end else if (rx_end && q.rx_busy) begin
      d.rx_busy = 1'b0;
      d.rx_pend = 1'b1;
      d.rx_irq = !(q.rx_chg || !dir16[q.rx_box]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ptr <= PTR_RST;
      q.en <= EN_RST;
      q.dir <= DIR_RST;
      q.transmit_request_bits <= TRS_RST;
      q.ta <= TA_RST;
    end else begin
      q <= d;
    end
  end

  // Priority check helper: no requester may beat the chosen box
  logic prio_ok;

  always_comb begin
    prio_ok = 1'b1;
    for (int i = 0; i < NBOX; i++) begin
      if (s.req[i] && (box_id[i*ID_W +: ID_W] < box_id[s.pick*ID_W +: ID_W])) begin
        prio_ok = 1'b0;
      end
    end
  end

  AST_DIR15_READS_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.ap_rd && !q.rd_wait && q.ap_idx == DIR_HI_IDX) |=> q.rdata[7])
    else $error("last box direction did not read as one");

  AST_NO_REQ_ON_RX: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.ap_wr && (q.ap_idx == TRS_LO_IDX || q.ap_idx == TRS_HI_IDX))
      |=> ((q.transmit_request_bits & ~$past(q.transmit_request_bits) & $past(q.dir)) == 15'h0000))
    else $error("request set on a receive mailbox");

  AST_SEND_KEEPS_REQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && !tx_ok && (tx_lost || tx_err)) |=> trs16[$past(q.box)])
    else $error("request cleared after a failed send");

  AST_OK_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && tx_ok) |=> (!trs16[$past(q.box)] && ta16[$past(q.box)] && q.st == ST_IDLE))
    else $error("success did not clear request and set ack");

  AST_ERR_SAME_BOX: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && q.order && tx_err && !tx_ok && !tx_lost)
      |=> (tx_go && q.box == $past(q.box) && q.st == ST_SEND))
    else $error("error retry left the failed mailbox");

  AST_FAIL_RESCAN: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && !q.order && !tx_ok && (tx_lost || tx_err)) |=> (q.ptr == $past(q.box)))
    else $error("scan did not restart at the failed mailbox");

  AST_ROTATE_NEXT: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && tx_ok) |=> (q.ptr == 4'($past(q.box) + 4'h1)))
    else $error("scan start is not the box after the last sent");

  AST_TX_NO_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && tx_ok && (q.tx_chg || dir16[q.box])) |=> (!tx_irq_set && ta16[$past(q.box)]))
    else $error("transmit irq raised after switch to receive");

  AST_RX_NO_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.rx_busy && rx_end && !rx_start && !dir16[q.rx_box]) |=> (rx_pend_set && !rx_irq_set))
    else $error("receive irq raised after switch to transmit");

  AST_START_VALID: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_IDLE && s.found) |=> (tx_go && $past(q.en[s.pick]) && !$past(dir16[s.pick])))
    else $error("send started on a disabled or receive mailbox");

  AST_WR_BLOCKED: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND) |-> !box_wr_ok[q.box])
    else $error("mailbox write allowed while request pending");

  AST_PRIO_PICK: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_IDLE && s.found && q.order) |-> prio_ok)
    else $error("a higher priority requester was passed over");

  AST_LOST_REPICK: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && q.order && tx_lost && !tx_ok) |=> (q.st == ST_IDLE && !tx_go))
    else $error("lost arbitration did not lead to a new choice");

  AST_REQ_NOT_CLEARED: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.ap_wr && (q.ap_idx == TRS_LO_IDX || q.ap_idx == TRS_HI_IDX) && !(q.st == ST_SEND && tx_ok))
      |=> (($past(q.transmit_request_bits) & ~q.transmit_request_bits) == 15'h0000))
    else $error("request cleared by a register write");

  AST_ACK_W1C: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.ap_wr && (q.ap_idx == TA_LO_IDX || q.ap_idx == TA_HI_IDX) && !(q.st == ST_SEND && tx_ok))
      |=> ((q.ta & $past(wv[14:0])) == 15'h0000))
    else $error("ack bit written with one stayed set");

  AST_ORDER_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.ap_wr && q.ap_idx == MCR_IDX) |=> (q.order == $past(w[ORDER_BIT])))
    else $error("transmit order select not taken from the write");

  AST_SEND_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && !tx_ok && !tx_lost && !tx_err)
      |=> (tx_busy && tx_box == $past(q.box)))
    else $error("send abandoned without a result");

  AST_EN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.ap_wr && q.ap_idx == EN_LO_IDX) |=> (q.en[7:0] == $past(w)))
    else $error("enable write did not land");

  AST_DIR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.ap_wr && q.ap_idx == DIR_LO_IDX) |=> (q.dir[7:0] == $past(w)))
    else $error("direction write did not land");

  AST_RX_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.rx_busy && rx_end && !rx_start && !q.rx_chg && dir16[q.rx_box]) |=> (rx_pend_set && rx_irq_set))
    else $error("clean reception raised no irq");

  AST_TX_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.st == ST_SEND && tx_ok && !q.tx_chg && !dir16[q.box]) |=> tx_irq_set)
    else $error("clean transmission raised no irq");

endmodule

// ### sim/can_engine_model.sv
`timescale 1ns/10ps
module can_engine_model (
  // Engine side
  input wire logic hclk,
  input wire logic tx_go,
  output logic tx_ok,
  output logic tx_lost,
  output logic tx_err,
  // Scenario control
  input wire logic [4:0] dly,
  input wire logic [3:0] fails,
  input wire logic lose
);
  int cnt = 0;
  int nf = 0;
  initial {tx_ok, tx_lost, tx_err} = 3'b000;
  // Result dly cycles after each start; fails counts failed frames over the whole run
  always @(posedge hclk) begin
    {tx_ok, tx_lost, tx_err} <= 3'b000;
    if (tx_go) cnt <= dly;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      if (nf < fails) begin
        nf <= nf + 1;
        if (lose) tx_lost <= 1'b1;
        else tx_err <= 1'b1;
      end else tx_ok <= 1'b1;
    end
  end
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
  import can_tx_pkg::*;
  logic hclk, hresetn, hsel, hwrite, rx_start, rx_end, lose;
  logic hreadyout, hresp, tx_go, tx_busy, tx_ok, tx_lost, tx_err, tx_irq_set, rx_pend_set, rx_irq_set;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic [NBOX*ID_W-1:0] box_id;
  logic [NBOX-1:0] box_wr_ok;
  logic [3:0] tx_box, rx_box_in, rx_pend_box, fails;
  logic [4:0] dly;
  logic [7:0] rv;
  logic [3:0] sent[$];
  int num_errors = 0;
  int total_checks = 0;
  int irqs = 0;
  // Bit time in clocks; arbitrary, the block itself has no bit timing
  localparam int BIT_CYC = 2;

  can_mailbox_tx_control can_mailbox_tx_control_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .box_id(box_id), .box_wr_ok(box_wr_ok),
    .tx_go(tx_go), .tx_box(tx_box), .tx_busy(tx_busy), .tx_ok(tx_ok), .tx_lost(tx_lost), .tx_err(tx_err),
    .tx_irq_set(tx_irq_set), .rx_start(rx_start), .rx_box_in(rx_box_in), .rx_end(rx_end),
    .rx_pend_set(rx_pend_set), .rx_irq_set(rx_irq_set), .rx_pend_box(rx_pend_box));
  can_engine_model can_engine_model_inst (.hclk(hclk), .tx_go(tx_go), .tx_ok(tx_ok), .tx_lost(tx_lost),
    .tx_err(tx_err), .dly(dly), .fails(fails), .lose(lose));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (tx_go === 1'b1) sent.push_back(tx_box);
    if (tx_irq_set === 1'b1) irqs++;
  end

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic wait_rdy;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) num_errors++;
  endtask

  task automatic xfer(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy;
    rv = hrdata[7:0];
    chk("hresp", hresp, 16'h0);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] e, input string nm);
    xfer(1'b0, idx, 8'h00);
    chk(nm, rv, e);
  endtask

  // Waits for n starts and an idle engine, then compares the start order
  task automatic sends(input int n, input logic [15:0] e, input string nm);
    int k = 0;
    logic [15:0] q = 16'h0;
    while ((sent.size() != n || tx_busy !== 1'b0) && k < 500) begin
      k++;
      @(posedge hclk);
    end
    if (sent.size() != n || tx_busy !== 1'b0) num_errors++;
    @(posedge hclk);
    foreach (sent[i]) q = {q[11:0], sent[i]};
    chk(nm, q, e);
    sent.delete();
  endtask

  task automatic t_reset;
    rd(EN_LO_IDX, 8'h00, "en low");
    rd(DIR_HI_IDX, 8'h80, "dir high");
    rd(14'h0100, 8'h00, "unmapped");
    chk("wr ok", box_wr_ok, 16'h0000);
    xfer(1'b1, DIR_HI_IDX, 8'h00);
    rd(DIR_HI_IDX, 8'h80, "dir high");
    xfer(1'b1, TRS_HI_IDX, 8'h80);
    rd(TRS_HI_IDX, 8'h00, "req high");
  endtask

  task automatic t_mode0;
    xfer(1'b1, EN_LO_IDX, 8'h3f);
    xfer(1'b1, DIR_LO_IDX, 8'h08);
    chk("wr ok", box_wr_ok, 16'h003f);
    xfer(1'b1, TRS_LO_IDX, 8'h0b);
    rd(TRS_LO_IDX, 8'h03, "req low");
    chk("wr ok", box_wr_ok, 16'h003c);
    xfer(1'b1, TRS_LO_IDX, 8'h00);
    rd(TRS_LO_IDX, 8'h03, "req low");
    sends(2, 16'h0001, "order");
    chk("irqs", irqs[15:0], 16'h0002);
    rd(TA_LO_IDX, 8'h03, "ack");
    xfer(1'b1, TA_LO_IDX, 8'h01);
    rd(TA_LO_IDX, 8'h02, "ack");
    xfer(1'b1, TRS_LO_IDX, 8'h05);
    sends(2, 16'h0020, "rotate");
    fails = 4'd1;
    lose = 1'b1;
    xfer(1'b1, TRS_LO_IDX, 8'h05);
    sends(3, 16'h0220, "lost");
    fails = 4'd2;
    lose = 1'b0;
    xfer(1'b1, TRS_LO_IDX, 8'h05);
    sends(3, 16'h0220, "err rescan");
    rd(TRS_LO_IDX, 8'h00, "req low");
  endtask

  // Identifiers change only on disabled boxes, after one longest frame
  task automatic set_ids;
    xfer(1'b1, EN_LO_IDX, 8'h38);
    repeat (FRAME_MAX_BITS * BIT_CYC) @(posedge hclk);
    chk("wr ok", box_wr_ok, 16'h0038);
    box_id[0+:11] <= 11'h300;
    box_id[11+:11] <= 11'h100;
    box_id[22+:11] <= 11'h200;
    xfer(1'b1, EN_LO_IDX, 8'h3f);
  endtask

  task automatic t_prio;
    set_ids;
    xfer(1'b1, MCR_IDX, 8'h08);
    xfer(1'b1, TRS_LO_IDX, 8'h07);
    sends(3, 16'h0120, "prio");
    fails = 4'd3;
    lose = 1'b0;
    xfer(1'b1, TRS_LO_IDX, 8'h05);
    sends(3, 16'h0220, "err");
    fails = 4'd4;
    lose = 1'b1;
    xfer(1'b1, TRS_LO_IDX, 8'h01);
    xfer(1'b1, TRS_LO_IDX, 8'h02);
    sends(3, 16'h0010, "repick");
  endtask

  task automatic t_rx;
    int i0;
    xfer(1'b1, DIR_LO_IDX, 8'h18);
    rx_box_in <= 4'd4;
    rx_start <= 1'b1;
    @(posedge hclk);
    rx_start <= 1'b0;
    xfer(1'b1, DIR_LO_IDX, 8'h08);
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
    @(posedge hclk);
    chk("rx", {rx_pend_set, rx_irq_set, rx_pend_box}, 16'h0024);
    rx_box_in <= 4'd3;
    rx_start <= 1'b1;
    @(posedge hclk);
    rx_start <= 1'b0;
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
    @(posedge hclk);
    chk("rx", {rx_pend_set, rx_irq_set, rx_pend_box}, 16'h0033);
    xfer(1'b1, TA_LO_IDX, 8'h3f);
    i0 = irqs;
    xfer(1'b1, TRS_LO_IDX, 8'h01);
    xfer(1'b1, DIR_LO_IDX, 8'h09);
    sends(1, 16'h0000, "switch");
    chk("irqs", irqs[15:0], i0[15:0]);
    rd(TA_LO_IDX, 8'h01, "ack");
  endtask

  task automatic test_done;
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, rx_start, rx_end, lose} = 5'b00000;
    haddr = 16'h0;
    htrans = 2'b00;
    hwdata = 32'h0;
    box_id = '1;
    rx_box_in = 4'h0;
    fails = 4'h0;
    dly = 5'd20;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_mode0;
    t_prio;
    t_rx;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    test_done;
  end
endmodule
